// File: msc_pkg.sv
// Purpose: shared constants and types for module sideband control
// Assumes: 200 MHz system clock
// Notes:   counts derive from times in ns
package msc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int LINK_PERIOD_NS  = 160;
  localparam int T_RESET_MIN_NS  = 10000;
  localparam int T_INIT_NS       = 20000;
  localparam int T_HOST_RESET_NS = 15000;
  // least times round up, longest down
  localparam int RESET_MIN_CYC   = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC        = T_INIT_NS / CLK_PERIOD_NS;
  localparam int HOST_RESET_CYC  = (T_HOST_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_QTR_CYC    = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int CNT_W           = 13;
  localparam logic [CNT_W-1:0] RESET_MIN_LAST  = CNT_W'(RESET_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] INIT_LAST       = CNT_W'(INIT_CYC - 1);
  localparam logic [CNT_W-1:0] HOST_RESET_LAST = CNT_W'(HOST_RESET_CYC - 1);
  localparam logic [3:0]       QTR_LAST        = 4'(LINK_QTR_CYC - 1);
  // ==========================================================
  // module memory
  localparam logic [6:0] DEV_ADDR    = 7'h50;
  localparam int         LANES       = 4;
  localparam logic [7:0] MEM_IDENT   = 8'h00;
  localparam logic [7:0] MEM_STATUS  = 8'h02;
  localparam logic [7:0] MEM_FLAGS   = 8'h03;
  localparam logic [7:0] MEM_CONTROL = 8'h56;
  localparam logic [7:0] MEM_MASK    = 8'h64;
  localparam int         STAT_DNR    = 0;
  localparam int         CTRL_LPOVR  = 0;
  // ==========================================================
  // host controller registers
  localparam logic [7:0] H_CTRL    = 8'h00;
  localparam logic [7:0] H_MEMADDR = 8'h01;
  localparam logic [7:0] H_WDATA   = 8'h02;
  localparam logic [7:0] H_GO      = 8'h03;
  localparam logic [7:0] H_STATUS  = 8'h04;
  localparam logic [7:0] H_RDATA   = 8'h05;
  localparam logic [7:0] H_IRQ     = 8'h06;
  localparam logic [7:0] H_MASK    = 8'h07;
  localparam int CTRL_SEL = 0;
  localparam int CTRL_LP  = 1;
  localparam int CTRL_RST = 2;
  localparam int GO_START = 0;
  localparam int GO_READ  = 1;
  localparam int IRQ_W    = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_MOD  = 1;
  localparam int IRQ_PRES = 2;
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    SLV_IDLE = 3'h0, SLV_IGNORE = 3'h1, SLV_RX = 3'h2,
    SLV_ACK = 3'h3, SLV_TX = 3'h4, SLV_TXACK = 3'h5
  } msc_slv_state_t;
  typedef enum logic [1:0] {
    MST_IDLE = 2'h0, MST_START = 2'h1, MST_BIT = 2'h2, MST_STOP = 2'h3
  } msc_mst_state_t;
endpackage : msc_pkg

// File: msc_link_if.sv
// Purpose: sideband pins between host board and module
// Assumes: pull-ups modelled here from the output enables
// Notes:   no clocking block; ends sample pins themselves
`timescale 1ns/1ps
`default_nettype none
interface msc_link_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sel_oe;
  logic sel_o;
  logic module_reset_n;
  logic low_power_request;
  logic int_oe;
  logic pres_oe;
  logic sda;
  logic module_select_n;
  logic interrupt_n;
  logic presence_n;
  // open-drain wires, pull-up on the host board
  assign sda             = ~(host_sda_oe | dev_sda_oe);
  assign interrupt_n     = ~int_oe;
  assign presence_n      = ~pres_oe;
  // internal pull-up in the module keeps an undriven select high
  assign module_select_n = sel_oe ? sel_o : 1'b1;
  modport device (input scl, sda, module_select_n, module_reset_n, low_power_request,
                  output dev_sda_oe, int_oe, pres_oe);
  modport host (output scl, host_sda_oe, sel_oe, sel_o, module_reset_n, low_power_request,
                input sda, interrupt_n, presence_n);
endinterface : msc_link_if
`default_nettype wire

// File: msc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to i_ref_clk
// Notes:   only the second stage may be read
`timescale 1ns/1ps
`default_nettype none
module msc_sync
  import msc_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // reset to each pin's idle level, so no false edge or level follows reset
      always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          meta[g]   <= RST_VAL[g];
          o_sync[g] <= RST_VAL[g];
        end else begin
          meta[g]   <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule : msc_sync
`default_nettype wire

// File: msc_device.sv
// Purpose: module end: 2-wire slave, reset/init, interrupt, low power
// Assumes: i_lane_fault is on i_ref_clk; link pins are asynchronous
// Notes:   i_sys_rst stands for power-up
//
// What this block does
// - answers 2-wire traffic while select is low
// - ignores 2-wire traffic while select high; the code samples select only at each start condition
// - select defaults high through internal pull-up
// - long reset low restores all defaults
// - init period starts at reset rising edge
// - host ignores status until reset completes
// - completion: interrupt low, not-ready bit cleared
// - power-up posts completion interrupt unprompted
// - low power request enters reduced consumption
// - interrupt low flags fault or critical status
// - host reads module to find cause
// - interrupt only pulled low, host pulls up
// - host reads flag byte for lane
`timescale 1ns/1ps
`default_nettype none
module msc_device
  import msc_pkg::*;
#(
  parameter logic [7:0] IDENT_VALUE = 8'hA5  // arbitrary value
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [LANES-1:0] i_lane_fault,
  output logic                  o_low_power,
  output logic                  o_data_not_ready,
  output logic                  o_in_reset,
  msc_link_if.device            link
);
  // ==========================================================
  // pin sampling
  logic [4:0] pins;
  logic       s_scl, s_sda, s_sel_n, s_rst_n, s_lp;
  logic       scl_q, sda_q, rst_q;

  // low power pin idles low, all others high; undriven select reads deselected
  msc_sync #(.W(5), .RST_VAL(5'h1E)) i_msc_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({link.scl, link.sda, link.module_select_n,
                 link.module_reset_n, link.low_power_request}),
    .o_sync    (pins)
  );
  assign {s_scl, s_sda, s_sel_n, s_rst_n, s_lp} = pins;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rst_q <= 1'b1;
    end else begin
      scl_q <= s_scl;
      sda_q <= s_sda;
      rst_q <= s_rst_n;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, rst_rise;
  assign scl_rise  = s_scl & ~scl_q;
  assign scl_fall  = ~s_scl & scl_q;
  assign bus_start = s_scl & scl_q & sda_q & ~s_sda;
  assign bus_stop  = s_scl & scl_q & ~sda_q & s_sda;
  assign rst_rise  = s_rst_n & ~rst_q;

  // ==========================================================
  // reset pin and initialisation
  logic [CNT_W-1:0] low_cnt;
  logic             armed;
  logic [CNT_W-1:0] init_cnt;
  logic             init_run;
  logic             full_reset;
  logic             init_done;

  // a short low glitch never arms, so it cannot wipe settings
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_cnt <= '0;
      armed   <= 1'b0;
    end else if (!s_rst_n) begin
      if (low_cnt == RESET_MIN_LAST) begin
        armed <= 1'b1;
      end else begin
        low_cnt <= low_cnt + 1'b1;
      end
    end else begin
      low_cnt <= '0;
      armed   <= 1'b0;
    end
  end
  assign full_reset = rst_rise & armed;
  assign init_done  = init_run & (init_cnt == INIT_LAST);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      init_run         <= 1'b1;
      init_cnt         <= '0;
      o_data_not_ready <= 1'b1;
    end else if (full_reset) begin
      init_run         <= 1'b1;
      init_cnt         <= '0;
      o_data_not_ready <= 1'b1;
    end else if (init_done) begin
      init_run         <= 1'b0;
      o_data_not_ready <= 1'b0;
    end else if (init_run) begin
      init_cnt <= init_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_in_reset <= 1'b1;
    end else begin
      o_in_reset <= init_run | full_reset | ~s_rst_n;  // no gap before init
    end
  end

  // ==========================================================
  // 2-wire slave
  msc_slv_state_t state;
  logic [3:0]     bitcnt;
  logic [7:0]     shreg;
  logic [1:0]     phase;
  logic           rw;
  logic [7:0]     ptr;
  logic           mem_wr;
  logic           mem_rd;
  logic [7:0]     acc_addr;
  logic [7:0]     wr_data;
  logic [7:0]     rdata;
  logic [7:0]     ctrl;
  logic [7:0]     mask;
  logic [LANES-1:0] flags;
  logic           comp_post;

  always_comb begin
    unique case (ptr)
      MEM_IDENT:   rdata = IDENT_VALUE;
      MEM_STATUS:  rdata = {7'h00, o_data_not_ready};
      MEM_FLAGS:   rdata = {{(8 - LANES){1'b0}}, flags};
      MEM_CONTROL: rdata = ctrl;
      MEM_MASK:    rdata = mask;
      default:     rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state    <= SLV_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      phase    <= 2'h0;
      rw       <= 1'b0;
      ptr      <= 8'h00;
      mem_wr   <= 1'b0;
      mem_rd   <= 1'b0;
      acc_addr <= 8'h00;
      wr_data  <= 8'h00;
    end else begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      if (bus_stop || !s_rst_n) begin
        state <= SLV_IDLE;
      end else if (bus_start) begin
        // decision held until the next start or stop condition or reset pin low
        state  <= s_sel_n ? SLV_IGNORE : SLV_RX;
        bitcnt <= 4'h0;
        phase  <= 2'h0;
        rw     <= 1'b0;
      end else begin
        unique case (state)
          SLV_IDLE, SLV_IGNORE: begin
          end
          SLV_RX: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], s_sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              state <= SLV_ACK;
              if (phase == 2'h0) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  rw    <= shreg[0];
                  phase <= 2'h1;
                end else begin
                  state <= SLV_IGNORE;
                end
              end else if (phase == 2'h1) begin
                ptr   <= shreg;
                phase <= 2'h2;
              end else begin
                mem_wr   <= 1'b1;
                acc_addr <= ptr;
                wr_data  <= shreg;
                ptr      <= ptr + 8'h01;
              end
            end
          end
          SLV_ACK, SLV_TXACK: begin
            if (state == SLV_TXACK && scl_rise && s_sda) begin
              state <= SLV_IGNORE;  // master nack ends the read
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rw) begin
                shreg    <= rdata;
                mem_rd   <= 1'b1;
                acc_addr <= ptr;
                ptr      <= ptr + 8'h01;
                state    <= SLV_TX;
              end else begin
                state <= SLV_RX;
              end
            end
          end
          SLV_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                state <= SLV_TXACK;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          default: state <= SLV_IDLE;
        endcase
      end
    end
  end

  // only ever pulls low
  assign link.dev_sda_oe = (state == SLV_ACK) | ((state == SLV_TX) & ~shreg[7]);

  // ==========================================================
  // settings, flags and interrupt
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl <= 8'h00;
      mask <= 8'h00;
    end else if (full_reset) begin
      ctrl <= 8'h00;
      mask <= 8'h00;
    end else if (mem_wr && acc_addr == MEM_CONTROL) begin
      ctrl <= wr_data;
    end else if (mem_wr && acc_addr == MEM_MASK) begin
      mask <= wr_data;
    end
  end

  // a fault in the cycle of the clearing read survives
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags <= '0;
    end else if (full_reset) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~{LANES{mem_rd && acc_addr == MEM_FLAGS}}) | i_lane_fault;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      comp_post <= 1'b0;
    end else if (init_done) begin
      comp_post <= 1'b1;
    end else if (full_reset || (mem_rd && acc_addr == MEM_STATUS)) begin
      comp_post <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link.int_oe <= 1'b0;
      o_low_power <= 1'b0;
    end else begin
      link.int_oe <= comp_post | (|(flags & ~mask[LANES-1:0]));
      o_low_power <= s_lp | ctrl[CTRL_LPOVR];
    end
  end

  assign link.pres_oe = 1'b1;  // presence pin grounded in the module
endmodule : msc_device
`default_nettype wire

// File: msc_host.sv
// Purpose: host board end: 2-wire master and sideband controller
// Assumes: software port on i_ref_clk, read data one cycle later
// Notes:   link clock made here by a divider
`timescale 1ns/1ps
`default_nettype none
module msc_host
  import msc_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  msc_link_if.host        link
);
  // ==========================================================
  // pins and software registers
  logic [2:0] pins;
  logic       s_sda, s_int_n, s_pres_n, int_q, pres_q;
  msc_sync #(.W(3)) i_msc_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({link.sda, link.interrupt_n, link.presence_n}),
    .o_sync    (pins)
  );
  assign {s_sda, s_int_n, s_pres_n} = pins;

  logic [1:0]       ctrl;
  logic [7:0]       memaddr, wdata, mem_rdata;
  logic [IRQ_W-1:0] irq_st, irq_mask, events;
  logic             busy, nack, ready, done, rst_active;
  logic [CNT_W-1:0] rst_cnt;
  logic             go;
  assign go = i_wr && i_addr == H_GO && i_wdata[GO_START] && !busy;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl     <= 2'h0;
      memaddr  <= 8'h00;
      wdata    <= 8'h00;
      irq_mask <= '0;
    end else if (i_wr) begin
      if (i_addr == H_CTRL) ctrl <= i_wdata[1:0];
      if (i_addr == H_MEMADDR) memaddr <= i_wdata;
      if (i_addr == H_WDATA) wdata <= i_wdata;
      if (i_addr == H_MASK) irq_mask <= i_wdata[IRQ_W-1:0];
    end
  end
  assign link.sel_oe            = ctrl[CTRL_SEL];  // undriven when off
  assign link.sel_o             = 1'b0;
  assign link.low_power_request = ctrl[CTRL_LP];

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_active <= 1'b0;
      rst_cnt    <= '0;
    end else if (i_wr && i_addr == H_CTRL && i_wdata[CTRL_RST]) begin
      rst_active <= 1'b1;
      rst_cnt    <= '0;
    end else if (rst_active) begin
      if (rst_cnt == HOST_RESET_LAST) rst_active <= 1'b0;
      rst_cnt <= rst_cnt + 1'b1;
    end
  end
  assign link.module_reset_n = ~rst_active;

  // status not trusted until the completion interrupt shows
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ready  <= 1'b0;
      int_q  <= 1'b1;
      pres_q <= 1'b1;
    end else begin
      int_q  <= s_int_n;
      pres_q <= s_pres_n;
      if (rst_active) ready <= 1'b0;
      else if (!s_int_n) ready <= 1'b1;
    end
  end

  assign events = {pres_q ^ s_pres_n, int_q & ~s_int_n, done};
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_st <= '0;
    end else begin
      irq_st <= (irq_st & ~((i_wr && i_addr == H_IRQ) ? i_wdata[IRQ_W-1:0] : '0)) | events;
    end
  end
  assign o_irq = |(irq_st & irq_mask);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        H_CTRL:    o_rdata <= {5'h00, rst_active, ctrl};
        H_MEMADDR: o_rdata <= memaddr;
        H_WDATA:   o_rdata <= wdata;
        H_STATUS:  o_rdata <= {3'h0, ~s_int_n, ~s_pres_n, ready, nack, busy};
        H_RDATA:   o_rdata <= mem_rdata;
        H_IRQ:     o_rdata <= {5'h00, irq_st};
        H_MASK:    o_rdata <= {5'h00, irq_mask};
        default:   o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // 2-wire master, four quarters per bit
  msc_mst_state_t state;
  logic [3:0] qcnt, bitn;
  logic [1:0] q;
  logic [2:0] byte_no;
  logic       op_read;
  logic [8:0] sh, rx;
  logic       tick;
  logic [7:0] next_byte;
  logic [2:0] byte_sel;
  assign tick = (qcnt == QTR_LAST);
  // inside a byte the following byte is loaded at its ack bit
  assign byte_sel = (state == MST_BIT) ? byte_no + 3'h1 : byte_no;

  always_comb begin
    unique case (byte_sel)
      3'h0:    next_byte = {DEV_ADDR, 1'b0};
      3'h1:    next_byte = memaddr;
      3'h2:    next_byte = wdata;
      3'h3:    next_byte = {DEV_ADDR, 1'b1};
      default: next_byte = 8'hFF;  // released for the module's data
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= MST_IDLE;
      qcnt <= 4'h0; q <= 2'h0; bitn <= 4'h0; byte_no <= 3'h0;
      op_read <= 1'b0; sh <= 9'h1FF; rx <= 9'h000;
      busy <= 1'b0; nack <= 1'b0; done <= 1'b0; mem_rdata <= 8'h00;
      link.scl <= 1'b1; link.host_sda_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      qcnt <= (tick || state == MST_IDLE) ? 4'h0 : qcnt + 4'h1;
      if (state == MST_IDLE) begin
        if (go) begin
          state <= MST_START; q <= 2'h0; byte_no <= 3'h0;
          op_read <= i_wdata[GO_READ]; busy <= 1'b1; nack <= 1'b0;
        end
      end else if (tick) begin
        q <= q + 2'h1;
        unique case (state)
          MST_START: begin
            unique case (q)
              2'h0: link.host_sda_oe <= 1'b0;
              2'h1: link.scl <= 1'b1;
              2'h2: link.host_sda_oe <= 1'b1;
              default: begin
                link.scl <= 1'b0; state <= MST_BIT; bitn <= 4'h0;
                sh <= {next_byte, 1'b1};
              end
            endcase
          end
          MST_BIT: begin
            unique case (q)
              2'h0: link.host_sda_oe <= ~sh[8];
              2'h1: link.scl <= 1'b1;
              2'h2: rx <= {rx[7:0], s_sda};
              default: begin
                link.scl <= 1'b0; sh <= {sh[7:0], 1'b1}; bitn <= bitn + 4'h1;
                if (bitn == 4'h8) begin
                  bitn <= 4'h0;
                  if (byte_no == 3'h4) begin
                    mem_rdata <= rx[8:1]; state <= MST_STOP;
                  end else if (rx[0]) begin
                    nack <= 1'b1; state <= MST_STOP;
                  end else if (!op_read && byte_no == 3'h2) begin
                    state <= MST_STOP;
                  end else if (op_read && byte_no == 3'h1) begin
                    byte_no <= 3'h3; state <= MST_START;  // repeated start
                  end else begin
                    // no start condition between bytes of one frame
                    byte_no <= byte_no + 3'h1;
                    sh      <= {next_byte, 1'b1};
                  end
                end
              end
            endcase
          end
          MST_STOP: begin
            unique case (q)
              2'h0: link.host_sda_oe <= 1'b1;
              2'h1: link.scl <= 1'b1;
              2'h2: link.host_sda_oe <= 1'b0;
              default: begin
                state <= MST_IDLE; busy <= 1'b0; done <= 1'b1;
              end
            endcase
          end
          default: state <= MST_IDLE;
        endcase
      end
    end
  end
endmodule : msc_host
`default_nettype wire

// File: msc_monitor.sv
// Purpose: link assertions for module sideband control
// Assumes: msc_link_if signals, one clock domain
// Notes:   instantiated beside the link, no bind
`timescale 1ns/1ps
`default_nettype none
module msc_monitor
  import msc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic scl,
  input wire logic dev_sda_oe,
  input wire logic sel_oe,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic int_oe,
  input wire logic interrupt_n,
  input wire logic presence_n
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // init timer; power-up counts as a reset release
  logic             armed;
  logic [CNT_W-1:0] since;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      armed <= 1'b1;
      since <= '0;
    end else if ($rose(module_reset_n)) begin
      armed <= 1'b1;
      since <= '0;
    end else begin
      armed <= armed && (since < INIT_LAST + 13'h10);
      since <= (since == '1) ? since : since + 13'h1;
    end
  end
  chk_init_time: assert property (
    $rose(int_oe) && armed |-> since >= INIT_LAST && since <= INIT_LAST + 13'h9)
    else $error("completion post outside init window");
  chk_reset_clears: assert property ($rose(module_reset_n) |-> ##8 !int_oe [*8])
    else $error("interrupt held across full reset");
  chk_desel_quiet: assert property (module_select_n |-> !dev_sda_oe)
    else $error("module drove data while deselected");
  chk_sel_pullup: assert property (!sel_oe |-> module_select_n)
    else $error("undriven select not high");
  chk_int_drain: assert property (interrupt_n == !int_oe)
    else $error("interrupt line not open drain");
  chk_sda_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("module changed data while clock high");
  chk_reset_idle: assert property (!module_reset_n [*4] |-> !dev_sda_oe)
    else $error("module drove data in reset");
  chk_present: assert property (!presence_n)
    else $error("presence line not low");
  cover property ($rose(int_oe) && armed);
  cover property ($rose(dev_sda_oe));
  cover property ($rose(module_reset_n));
endmodule : msc_monitor
`default_nettype wire

// File: test_module_sideband_control.sv
// Purpose: self-checking bench, host and module joined by the link
// Assumes: shared reset stands for power-up of both ends
// Notes:   select and reset pin driven through host registers
`timescale 1ns/1ps
`default_nettype none
module test_module_sideband_control
  import msc_pkg::*;
();
  logic       ref_clk;
  logic       sys_rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq;
  logic [3:0] flt;
  logic       lp;
  logic       dnr;
  logic       in_rst;
  logic [7:0] v;
  int         miscompares;
  int         n_checks;
  msc_link_if i_msc_link_if ();
  msc_host i_msc_host (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .link(i_msc_link_if.host));
  msc_device i_msc_device (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_lane_fault(flt),
    .o_low_power(lp), .o_data_not_ready(dnr), .o_in_reset(in_rst),
    .link(i_msc_link_if.device));
  msc_monitor i_msc_monitor (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .scl(i_msc_link_if.scl), .dev_sda_oe(i_msc_link_if.dev_sda_oe),
    .sel_oe(i_msc_link_if.sel_oe), .module_select_n(i_msc_link_if.module_select_n),
    .module_reset_n(i_msc_link_if.module_reset_n), .int_oe(i_msc_link_if.int_oe),
    .interrupt_n(i_msc_link_if.interrupt_n), .presence_n(i_msc_link_if.presence_n));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      miscompares++;
      summarize();
    end
  endtask : bound
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : rreg
  // leaves the last status read in v
  task automatic xfer(input logic [7:0] a, input logic rdf, input logic [7:0] d);
    int i;
    wreg(H_MEMADDR, a);
    wreg(H_WDATA, d);
    wreg(H_GO, {6'h00, rdf, 1'b1});
    for (i = 0; i < 3000; i++) begin
      rreg(H_STATUS);
      if (v[0] === 1'b0) break;
    end
    bound(i, 3000);
  endtask : xfer
  task automatic wait_dnr(input logic val);
    int i;
    for (i = 0; i < 8000 && dnr !== val; i++) @(negedge ref_clk);
    bound(i, 8000);
  endtask : wait_dnr
  task automatic t_power_up();
    wait_dnr(1'b0);
    repeat (4) @(negedge ref_clk);
    chk(8'(i_msc_link_if.interrupt_n), 8'h00);
    chk(8'(i_msc_link_if.module_select_n), 8'h01);
    rreg(H_STATUS);
    chk(v & 8'h0C, 8'h0C);
    $display("power_up done");
  endtask : t_power_up
  task automatic t_status();
    wreg(H_MASK, 8'h00);
    wreg(H_CTRL, 8'h01);
    xfer(MEM_STATUS, 1'b1, 8'h00);
    chk(v & 8'h02, 8'h00);
    rreg(H_RDATA);
    chk(v & 8'h01, 8'h00);
    chk(8'(irq), 8'h00);
    wreg(H_MASK, 8'h01);
    #1;
    chk(8'(irq), 8'h01);
    wreg(H_IRQ, 8'h07);
    #1;
    chk(8'(irq), 8'h00);
    chk(8'(i_msc_link_if.interrupt_n), 8'h01);
    rreg(8'h10);
    chk(v, 8'h00);
    $display("status done");
  endtask : t_status
  task automatic t_fault();
    @(posedge ref_clk);
    flt <= 4'h4;
    @(posedge ref_clk);
    flt <= 4'h0;
    repeat (4) @(negedge ref_clk);
    chk(8'(i_msc_link_if.interrupt_n), 8'h00);
    xfer(MEM_FLAGS, 1'b1, 8'h00);
    rreg(H_RDATA);
    chk(v, 8'h04);
    repeat (4) @(negedge ref_clk);
    chk(8'(i_msc_link_if.interrupt_n), 8'h01);
    $display("fault done");
  endtask : t_fault
  task automatic t_deselect();
    wreg(H_CTRL, 8'h00);
    xfer(MEM_STATUS, 1'b1, 8'h00);
    chk(v & 8'h02, 8'h02);
    $display("deselect done");
  endtask : t_deselect
  task automatic t_low_power();
    wreg(H_CTRL, 8'h03);
    repeat (8) @(negedge ref_clk);
    chk(8'(lp), 8'h01);
    wreg(H_CTRL, 8'h01);
    repeat (8) @(negedge ref_clk);
    chk(8'(lp), 8'h00);
    $display("low_power done");
  endtask : t_low_power
  task automatic t_reset();
    xfer(MEM_CONTROL, 1'b0, 8'h01);
    repeat (8) @(negedge ref_clk);
    chk(8'(lp), 8'h01);
    wreg(H_CTRL, 8'h05);
    wait_dnr(1'b1);
    chk(8'(in_rst), 8'h01);
    rreg(H_STATUS);
    chk(v & 8'h04, 8'h00);
    wait_dnr(1'b0);
    repeat (4) @(negedge ref_clk);
    chk(8'(lp), 8'h00);
    chk(8'(i_msc_link_if.interrupt_n), 8'h00);
    rreg(H_STATUS);
    chk(v & 8'h14, 8'h14);
    $display("reset done");
  endtask : t_reset
  initial begin
    sys_rst     = 1'b1;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    flt         = 4'h0;
    miscompares = 0;
    n_checks    = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_power_up();
    t_status();
    t_fault();
    t_deselect();
    t_low_power();
    t_reset();
    summarize();
  end
endmodule : test_module_sideband_control
`default_nettype wire
